//--- design/cwa_defines.vh
`ifndef CWA_DEFINES_VH
`define CWA_DEFINES_VH

// register indices on the management port
`define CWA_ADDR_ADVERTISE      5'h04
`define CWA_ADDR_PARTNER        5'h05

// clock and documented times
`define CWA_CLK_MHZ             50
`define CWA_LINK_TIME_BASEX_US  10000
`define CWA_LINK_TIME_SGMII_US  1600
`define CWA_WATCHDOG_TIME_MS    5000

// configuration word fields
`define CWA_BIT_SGMII_ONE       0
`define CWA_BIT_FULL_DUPLEX     5
`define CWA_BIT_HALF_DUPLEX     6
`define CWA_POS_PAUSE           7
`define CWA_POS_SPEED           10
`define CWA_BIT_SGMII_DUPLEX    12
`define CWA_POS_REMOTE_FAULT    12
`define CWA_BIT_ACK             14
`define CWA_BIT_NEXT_PAGE       15
`define CWA_BIT_LINK_UP         15

// field encodings
`define CWA_RF_NO_ERROR         2'h0
`define CWA_RF_LINK_FAIL        2'h1
`define CWA_RF_OFF_LINE         2'h2
`define CWA_RF_AN_ERROR         2'h3
`define CWA_PAUSE_NONE          2'h0
`define CWA_PAUSE_SYM           2'h1
`define CWA_PAUSE_ASYM          2'h2
`define CWA_PAUSE_BOTH          2'h3
`define CWA_SPEED_10            2'h0
`define CWA_SPEED_100           2'h1
`define CWA_SPEED_1000          2'h2

// reset values
`define CWA_ADV_RESET_BASEX     16'h0020
`define CWA_ADV_RESET_SGMII     16'h9001
`define CWA_ADV_SGMII_RECEIVER  16'h0001
`define CWA_ADV_WRITE_MASK      16'hBFFF
`define CWA_STRAP_RXD_AN        2'h2

`endif

//--- design/cwa_autoneg.v
// Notes on behaviour
// - exchange starts only on a start write while negotiation is enabled, or on watchdog expiry
// - send the advertisement word with acknowledge bit 14 cleared
// - nonzero received word: set ack, store word, set both page flags
// - stop sending at link timer end: 10ms base-x, 1.6ms sgmii
// - watchdog restarts negotiation after 5s without link unless disabled
// - no next-page exchange; only the base word is exchanged
// - link-down outside disable-ok and link-ok states clears link status, squelches clocks
// - 15-pin straps 10, strap two high, valid high: base-x, enabled
// - 3-pin straps with strap two high select base-x, enabled
// - base-x reset advertisement is full duplex only, no pause, no fault
// - base-x word: fd 5, hd 6, pause 7-8, fault 12-13, ack 14, np 15
// - fault field: 00 none, 01 link fail, 10 off line, 11 an error
// - pause field: 00 none, 01 sym, 10 asym, 11 both
// - received register is read only; bit 14 is partner acknowledge
// - mode bit zero selects sgmii control transfer, either direction
// - sgmii word: one at 0, speed 10-11, duplex 12, ack 14, link 15
// - 15-pin straps 10, strap two low: sgmii, enabled, speed from straps
// - 3-pin strap two low: sgmii, enabled, speed 1000, full duplex, link up
// - sgmii speed: 00 10M, 01 100M, 10 1000M, 11 reserved
`include "cwa_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module cwa_autoneg #(
    parameter LINK_BASEX_CYC = `CWA_LINK_TIME_BASEX_US * `CWA_CLK_MHZ,
    parameter LINK_SGMII_CYC = `CWA_LINK_TIME_SGMII_US * `CWA_CLK_MHZ,
    parameter WATCHDOG_CYC   = `CWA_WATCHDOG_TIME_MS * 1000 * `CWA_CLK_MHZ
) (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [4:0]  mgmt_addr,
    input  wire        mgmt_wr,
    input  wire        mgmt_rd,
    input  wire [15:0] mgmt_wdata,
    output reg  [15:0] mgmt_rdata,
    output reg         mgmt_rvalid,
    input  wire        ctl_wr,
    input  wire        ctl_an_enable,
    input  wire        ctl_mode_basex,
    input  wire        ctl_wd_disable,
    input  wire        ctl_squelch,
    input  wire        an_start,
    input  wire        status_read,
    input  wire        page_clear,
    input  wire        strap_col,
    input  wire [1:0]  strap_rxd,
    input  wire        strap_general_output_strap_two,
    input  wire        strap_rx_dv,
    input  wire        rx_cfg_valid,
    input  wire [15:0] rx_cfg_word,
    output reg         tx_cfg_en,
    output reg  [15:0] tx_cfg_word,
    output reg         an_enable,
    output reg         mode_basex,
    output reg         wd_disable,
    output reg         squelch_en,
    output reg         link_down,
    output reg         link_status,
    output reg         page_received,
    output reg         page_irq,
    output reg         gpio_clk_squelch
);

    localparam ST_DISABLE_OK = 3'h0;
    localparam ST_IDLE       = 3'h1;
    localparam ST_ABILITY    = 3'h2;
    localparam ST_ACK        = 3'h3;
    localparam ST_WAIT       = 3'h4;
    localparam ST_LINK_OK    = 3'h5;

    localparam [27:0] LINK_BASEX = LINK_BASEX_CYC[27:0];
    localparam [27:0] LINK_SGMII = LINK_SGMII_CYC[27:0];
    localparam [27:0] WATCHDOG   = WATCHDOG_CYC[27:0];

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [15:0] advertise;
    reg  [15:0] partner;
    reg  [27:0] link_cnt;
    reg  [27:0] wd_cnt;
    reg         wd_run;
    reg  [4:0]  strap_s1;
    reg  [4:0]  strap_s2;
    reg         strap_done;
    reg  [1:0]  strap_wait;
    reg  [15:0] next_tx_word;
    reg         link_timer_done;
    reg         wd_expired;
    reg         restart;
    reg         page_event;

    wire        rx_page = rx_cfg_valid && (rx_cfg_word != 16'h0000);
    wire [27:0] link_limit = mode_basex ? LINK_BASEX : LINK_SGMII;

    // straps cross in from pins through two flops
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            strap_s1 <= 5'h00;
            strap_s2 <= 5'h00;
        end else begin
            strap_s1 <= {strap_col, strap_rxd, strap_general_output_strap_two, strap_rx_dv};
            strap_s2 <= strap_s1;
        end
    end

    // combinational next state
    always @* begin
        link_timer_done = (link_cnt >= link_limit - 28'h0000001);
        wd_expired = wd_run && !wd_disable
                     && (wd_cnt >= WATCHDOG - 28'h0000001);
        restart = (an_start && an_enable) || wd_expired;
        page_event = 1'b0;
        next_state = state;
        if (!an_enable) begin
            next_state = ST_DISABLE_OK;
        end else if (restart) begin
            next_state = ST_ABILITY;
        end else begin
            case (state)
                ST_DISABLE_OK: begin
                    next_state = ST_IDLE;
                end
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_ABILITY: begin
                    if (rx_page) begin
                        next_state = ST_ACK;
                        page_event = 1'b1;
                    end else if (link_timer_done) begin
                        next_state = ST_WAIT;
                    end
                end
                ST_ACK: begin
                    if (link_timer_done) begin
                        next_state = ST_LINK_OK;
                    end
                end
                ST_WAIT: begin
                    next_state = ST_WAIT;
                end
                ST_LINK_OK: begin
                    next_state = ST_LINK_OK;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // word on the wire, assembled field by field from the advertisement
    always @* begin
        next_tx_word = advertise;
        // acknowledge is owned here, never by software
        next_tx_word[`CWA_BIT_ACK] = (next_state == ST_ACK);
        if (mode_basex) begin
            // fault and pause fields pass through as software coded them
            next_tx_word[`CWA_BIT_NEXT_PAGE] = 1'b0;
            next_tx_word[11:9] = 3'h0;
            next_tx_word[4:0]  = 5'h00;
        end else begin
            // speed 11:10, duplex 12 and link 15 pass through
            next_tx_word[`CWA_BIT_SGMII_ONE] = 1'b1;
            next_tx_word[9:1] = 9'h000;
            next_tx_word[13]  = 1'b0;
        end
    end

    // negotiation state, link timer and watchdog
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            link_cnt <= 28'h0000000;
            wd_cnt   <= 28'h0000000;
            wd_run   <= 1'b0;
        end else begin
            state <= next_state;
            // both timers count the fixed system clock
            if (next_state != state || restart) begin
                link_cnt <= 28'h0000000;
            end else if (!link_timer_done) begin
                link_cnt <= link_cnt + 28'h0000001;
            end
            if (restart) begin
                wd_cnt <= 28'h0000000;
                wd_run <= 1'b1;
            end else if (next_state == ST_LINK_OK || !an_enable) begin
                wd_cnt <= 28'h0000000;
                wd_run <= 1'b0;
            end else if (wd_run) begin
                wd_cnt <= wd_cnt + 28'h0000001;
            end
        end
    end

    // control bits: straps load enable, mode and advertisement once after reset, then software
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            an_enable  <= 1'b0;
            mode_basex <= 1'b1;
            wd_disable <= 1'b0;
            squelch_en <= 1'b0;
            strap_done <= 1'b0;
            strap_wait <= 2'h0;
            advertise  <= `CWA_ADV_RESET_BASEX;
        end else begin
            // the second sync flop holds a real pin sample from edge three
            if (strap_wait != 2'h2) begin
                strap_wait <= strap_wait + 2'h1;
            end
            if (!strap_done && strap_wait == 2'h2
                && strap_s1 == strap_s2) begin
                strap_done <= 1'b1;
                if (strap_s2[4] || (strap_s2[3:2] == `CWA_STRAP_RXD_AN
                                    && strap_s2[0])) begin
                    an_enable  <= 1'b1;
                    mode_basex <= strap_s2[1];
                    if (strap_s2[1]) begin
                        advertise <= `CWA_ADV_RESET_BASEX;
                    end else begin
                        // full duplex, link up, speed from the straps
                        advertise <= `CWA_ADV_RESET_SGMII
                            | {4'h0, (strap_s2[4] ? `CWA_SPEED_1000
                                     : strap_s2[3:2]), 10'h000};
                    end
                end
            end else begin
                if (ctl_wr) begin
                    an_enable  <= ctl_an_enable;
                    mode_basex <= ctl_mode_basex;
                    wd_disable <= ctl_wd_disable;
                    squelch_en <= ctl_squelch;
                end
                if (mgmt_wr && mgmt_addr == `CWA_ADDR_ADVERTISE) begin
                    // bit 14 is owned by the acknowledge logic;
                    // fault and pause codes are stored as written
                    advertise <= mgmt_wdata & `CWA_ADV_WRITE_MASK;
                end
            end
        end
    end

    // transmitted word, received register and page flags
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_cfg_en     <= 1'b0;
            tx_cfg_word   <= 16'h0000;
            partner       <= 16'h0000;
            page_received <= 1'b0;
            page_irq      <= 1'b0;
        end else begin
            tx_cfg_en <= (next_state == ST_ABILITY)
                         || (next_state == ST_ACK);
            // next page is never offered: only the base word goes out
            tx_cfg_word <= next_tx_word;
            if (page_event) begin
                partner <= rx_cfg_word;
            end
            // a new page wins over a clear in the same cycle
            if (page_event) begin
                page_received <= 1'b1;
                page_irq      <= 1'b1;
            end else if (page_clear) begin
                page_received <= 1'b0;
                page_irq      <= 1'b0;
            end
        end
    end

    // link-down, link status (cleared on link-down, set again the cycle after it ends), clock squelch
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            link_down        <= 1'b1;
            link_status      <= 1'b0;
            gpio_clk_squelch <= 1'b0;
        end else begin
            link_down <= !(next_state == ST_DISABLE_OK
                           || next_state == ST_LINK_OK);
            gpio_clk_squelch <= squelch_en && link_down;
            if (link_down) begin
                link_status <= 1'b0;
            end else if (status_read || !link_status) begin
                link_status <= 1'b1;
            end
        end
    end

    // register reads, answered one cycle after the strobe
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            mgmt_rdata  <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt_rd;
            if (mgmt_rd) begin
                case (mgmt_addr)
                    `CWA_ADDR_ADVERTISE: begin
                        mgmt_rdata <= advertise & `CWA_ADV_WRITE_MASK;
                    end
                    `CWA_ADDR_PARTNER: begin
                        mgmt_rdata <= partner;
                    end
                    default: begin
                        mgmt_rdata <= 16'h0000;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

//--- bench/cwa_autoneg_props.sv
`timescale 1ns/100ps
`default_nettype none
module cwa_autoneg_props (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        mgmt_rd,
    input wire logic        mgmt_rvalid,
    input wire logic        an_start,
    input wire logic        an_enable,
    input wire logic        mode_basex,
    input wire logic        squelch_en,
    input wire logic        page_clear,
    input wire logic        tx_cfg_en,
    input wire logic [15:0] tx_cfg_word,
    input wire logic        link_down,
    input wire logic        link_status,
    input wire logic        page_received,
    input wire logic        page_irq,
    input wire logic        gpio_clk_squelch
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_start_sends_word: assert property (
        an_start && an_enable |=> tx_cfg_en && !tx_cfg_word[14])
        else $error("no word after start");
    a_ack_with_page: assert property (
        $rose(page_received) |-> tx_cfg_word[14])
        else $error("page without ack");
    a_flags_pair: assert property (
        page_irq == page_received) else $error("page flags differ");
    a_flag_sticky: assert property (
        page_received && !page_clear |=> page_received)
        else $error("page flag lost");
    a_down_clears_status: assert property (
        link_down |=> !link_status) else $error("status kept on down");
    a_squelch_follows: assert property (
        1'b1 |=> gpio_clk_squelch == $past(squelch_en && link_down))
        else $error("squelch wrong");
    a_no_next_page: assert property (
        tx_cfg_en && mode_basex |-> !tx_cfg_word[15])
        else $error("next page sent");
    a_read_answer: assert property (
        1'b1 |=> mgmt_rvalid == $past(mgmt_rd)) else $error("read valid");
    c_page: cover property ($rose(page_received));
    c_squelch: cover property (gpio_clk_squelch);
    c_link: cover property ($rose(link_status));
endmodule
bind cwa_autoneg cwa_autoneg_props cwa_autoneg_props_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .mgmt_rd(mgmt_rd),
    .mgmt_rvalid(mgmt_rvalid), .an_start(an_start), .an_enable(an_enable),
    .mode_basex(mode_basex), .squelch_en(squelch_en),
    .page_clear(page_clear), .tx_cfg_en(tx_cfg_en),
    .tx_cfg_word(tx_cfg_word), .link_down(link_down),
    .link_status(link_status), .page_received(page_received),
    .page_irq(page_irq), .gpio_clk_squelch(gpio_clk_squelch));
`default_nettype wire

//--- bench/cwa_partner.sv
`timescale 1ns/100ps
`default_nettype none
module cwa_partner #(
    parameter int DLY = 3
) (
    input  wire logic        sys_clk,
    input  wire logic        tx_cfg_en,
    input  wire logic        ans_en,
    input  wire logic [15:0] ans_word,
    output var  logic        rx_cfg_valid,
    output var  logic [15:0] rx_cfg_word
);
    int cnt = 0;
    initial rx_cfg_valid = 1'b0;
    initial rx_cfg_word = 16'h0000;
    // answers only while words arrive; idle word toggles so it is never stale
    always @(posedge sys_clk) begin
        cnt <= tx_cfg_en ? cnt + 1 : 0;
        rx_cfg_valid <= ans_en && tx_cfg_en && cnt >= DLY;
        if (ans_en && tx_cfg_en && cnt >= DLY) begin
            rx_cfg_word <= ans_word;
        end else begin
            rx_cfg_word <= ~rx_cfg_word;
        end
    end
endmodule
`default_nettype wire

//--- bench/cwa_autoneg_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
 $display("mismatch %0t %h %h", $time, (a), (b)); end end
`define WT(c) for (k = 0; k < 400 && !(c); k++) @(negedge sys_clk);
module cwa_autoneg_tb_top;
    localparam int LB = 20;
    localparam int LS = 10;
    logic sys_clk = 0, rst_n = 0, mgmt_wr = 0, mgmt_rd = 0, ctl_wr = 0;
    logic ctl_an_enable = 0, ctl_mode_basex = 0, ctl_wd_disable = 0;
    logic ctl_squelch = 0, an_start = 0, status_read = 0, page_clear = 0;
    logic strap_col = 1, strap_general_output_strap_two = 1, strap_rx_dv = 0, ans_en = 0;
    logic [1:0]  strap_rxd = 2'h0;
    logic [4:0]  mgmt_addr = 5'h00;
    logic [15:0] mgmt_wdata = 16'h0000, ans_word = 16'h0000, d;
    logic [15:0] mgmt_rdata, tx_cfg_word, rx_cfg_word;
    logic mgmt_rvalid, rx_cfg_valid, tx_cfg_en, an_enable, mode_basex;
    logic wd_disable, squelch_en, link_down, link_status, page_received;
    logic page_irq, gpio_clk_squelch;
    int n_errors = 0, n_tests = 0, k, n, cyc = 0;
    cwa_autoneg #(.LINK_BASEX_CYC(LB), .LINK_SGMII_CYC(LS),
        .WATCHDOG_CYC(200)) cwa_autoneg_inst (.sys_clk, .rst_n,
        .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata,
        .mgmt_rvalid, .ctl_wr, .ctl_an_enable, .ctl_mode_basex,
        .ctl_wd_disable, .ctl_squelch, .an_start, .status_read,
        .page_clear, .strap_col, .strap_rxd, .strap_general_output_strap_two, .strap_rx_dv,
        .rx_cfg_valid, .rx_cfg_word, .tx_cfg_en, .tx_cfg_word, .an_enable,
        .mode_basex, .wd_disable, .squelch_en, .link_down, .link_status,
        .page_received, .page_irq, .gpio_clk_squelch);
    cwa_partner cwa_partner_inst (.sys_clk, .tx_cfg_en, .ans_en, .ans_word,
        .rx_cfg_valid, .rx_cfg_word);
    initial forever #10 sys_clk = ~sys_clk;
    task automatic results;
        if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            results();
        end
    end
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge sys_clk);
        s = 0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        mgmt_addr = a;
        mgmt_wdata = v;
        pulse(mgmt_wr);
    endtask
    task automatic rd(input logic [4:0] a);
        mgmt_addr = a;
        pulse(mgmt_rd);
        `WT(mgmt_rvalid === 1'b1)
        d = mgmt_rdata;
    endtask
    task automatic ctl(input logic e, b, w, q);
        ctl_an_enable = e;
        ctl_mode_basex = b;
        ctl_wd_disable = w;
        ctl_squelch = q;
        pulse(ctl_wr);
    endtask
    task automatic count_tx;
        `WT(tx_cfg_en === 1'b1)
        n = 0;
        while (tx_cfg_en === 1'b1 && n < 100) begin
            n++;
            @(negedge sys_clk);
        end
    endtask
    task automatic t_strap_regs;
        `CHK(an_enable, 1'b1)
        `CHK(mode_basex, 1'b1)
        rd(`CWA_ADDR_ADVERTISE);
        `CHK(d, 16'h0020)
        wr(`CWA_ADDR_ADVERTISE, 16'hFFFF);
        rd(`CWA_ADDR_ADVERTISE);
        `CHK(d, 16'hBFFF)
        wr(`CWA_ADDR_PARTNER, 16'h1234);
        rd(`CWA_ADDR_PARTNER);
        `CHK(d, 16'h0000)
        rd(5'h07);
        `CHK(d, 16'h0000)
    endtask
    task automatic t_basex_page;
        wr(`CWA_ADDR_ADVERTISE, 16'h01A0);
        ans_word = 16'h40A0;
        ans_en = 1;
        pulse(an_start);
        `WT(tx_cfg_en === 1'b1)
        `CHK(tx_cfg_word, 16'h01A0)
        `WT(page_received === 1'b1)
        `CHK(tx_cfg_word[14], 1'b1)
        `CHK(page_irq, 1'b1)
        rd(`CWA_ADDR_PARTNER);
        `CHK(d, 16'h40A0)
        `WT(link_status === 1'b1)
        `CHK(link_down, 1'b0)
        `CHK(tx_cfg_en, 1'b0)
        pulse(status_read);
        `CHK(link_status, 1'b1)
        pulse(page_clear);
        `CHK(page_received, 1'b0)
        ans_en = 0;
    endtask
    task automatic t_timer_watchdog;
        wr(`CWA_ADDR_ADVERTISE, 16'h3020);
        pulse(an_start);
        `WT(tx_cfg_en === 1'b1)
        `CHK(tx_cfg_word, 16'h3020)
        count_tx();
        `CHK(n, LB)
        `WT(tx_cfg_en === 1'b1)
        `CHK(tx_cfg_en, 1'b1)
        ctl(1, 1, 1, 0);
        `CHK(wd_disable, 1'b1)
        `WT(tx_cfg_en === 1'b0)
        repeat (250) @(negedge sys_clk);
        `CHK(tx_cfg_en, 1'b0)
    endtask
    task automatic t_sgmii;
        ctl(1, 0, 1, 1);
        `CHK(squelch_en, 1'b1)
        wr(`CWA_ADDR_ADVERTISE, 16'h0001);
        ans_word = 16'hD801;
        ans_en = 1;
        pulse(an_start);
        `WT(tx_cfg_en === 1'b1)
        `CHK(tx_cfg_word, 16'h0001)
        repeat (2) @(negedge sys_clk);
        `CHK(gpio_clk_squelch, 1'b1)
        `WT(page_received === 1'b1)
        rd(`CWA_ADDR_PARTNER);
        `CHK(d, 16'hD801)
        ans_en = 0;
        `WT(tx_cfg_en === 1'b0)
        pulse(an_start);
        count_tx();
        `CHK(n, LS)
        ctl(0, 1, 0, 0);
        pulse(an_start);
        repeat (3) @(negedge sys_clk);
        `CHK(tx_cfg_en, 1'b0)
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1;
        repeat (8) @(negedge sys_clk);
        t_strap_regs();
        t_basex_page();
        t_timer_watchdog();
        t_sgmii();
        results();
    end
endmodule
`default_nettype wire
